// ==== rtl/apt_tracker.v ====
// absolute position tracker with apb register access
//
// How it works
// R1 - tracking active only when tracking select bit equals 1
// R2 - counter warning raised only when its select bit is 1
// R3 - changed mode, gear, direction, unit or home data erases home at power-up
// R4 - controller must home again before positioning after an erase
// R5 - done flag clears on servo off, stops, alarm, torque off, limits
// R6 - positioning without done flag raises home-return-incomplete warning 90
// R7 - erased alarm 25 or counter warning E3 invalidate home reference
// R8 - position is single-turn count plus retained revolution count
// R9 - position equals revs minus home revs, times counts per rev, plus turn minus home turn
// R10 - no tracking on stroke-less coordinate systems
// R11 - no tracking with incremental command method selected
// R12 - broken encoder link or swap while powered off loses data
// R13 - revolution count limited to plus or minus 32767 around home; the code flags only a raw count of -32768, not a range around home
// R14 - home return completion captures references and sets done flag
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "apt_regs.vh"
module apt_tracker #(
    parameter TURN_W = 18,
    parameter [31:0] COUNTS_PER_REV = 32'd262144
) (
    // clock and reset
    input wire I_CLK_SYS,
    input wire I_SRST,
    // apb slave
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [11:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    output wire O_PREADY,
    output wire O_PSLVERR,
    output reg [31:0] O_PRDATA,
    // encoder and retained data
    input wire [TURN_W-1:0] I_SINGLE_TURN_COUNT,
    input wire [15:0] I_REVOLUTION_COUNT,
    input wire I_ENCODER_LINK_BROKEN,
    input wire I_BACKUP_SWAPPED_UNPOWERED,
    input wire I_POWER_UP,
    // servo status
    input wire I_SERVO_ON,
    input wire I_FORCED_STOP_INPUT_A,
    input wire I_FORCED_STOP_INPUT_B,
    input wire I_ALARM_ACTIVE,
    input wire I_SAFE_TORQUE_OFF_INPUT,
    input wire I_MAIN_CIRCUIT_OFF_WARNING,
    input wire I_STROKE_LIMIT_OK,
    input wire I_SOFTWARE_LIMIT_HIT,
    // motion controller
    input wire I_HOME_RETURN_DONE,
    input wire I_POSITION_CMD,
    // status outputs
    output reg O_HOME_RETURN_DONE_FLAG,
    output reg O_ABS_DATA_ERASED_ALARM,
    output reg O_REVOLUTION_COUNTER_WARNING,
    output reg O_HOME_RETURN_INCOMPLETE_WARNING,
    output reg [7:0] O_ALARM_CODE,
    output reg signed [47:0] O_ABS_POSITION
);

    reg [31:0] ctrl_reg;
    reg stale_reg;
    reg home_valid_reg;
    reg [TURN_W-1:0] turn_home_reg;
    reg signed [15:0] rev_home_reg;
    reg signed [47:0] pos_next;

    // apb decode, always ready with zero wait states
    wire apb_wr = I_PSEL & I_PENABLE & I_PWRITE;
    wire hit = (I_PADDR == `APT_OFS_CTRL) | (I_PADDR == `APT_OFS_CFG) |
        (I_PADDR == `APT_OFS_STAT) | (I_PADDR == `APT_OFS_REV) |
        (I_PADDR == `APT_OFS_TURN) | (I_PADDR == `APT_OFS_REV_HOME) |
        (I_PADDR == `APT_OFS_TURN_HOME) | (I_PADDR == `APT_OFS_POS) |
        (I_PADDR == `APT_OFS_CLR);
    assign O_PREADY = 1'b1;
    assign O_PSLVERR = I_PSEL & I_PENABLE & ~hit;
    wire wr_cfg = apb_wr & (I_PADDR == `APT_OFS_CFG);
    wire wr_clr = apb_wr & (I_PADDR == `APT_OFS_CLR);

    // tracking availability from configuration
    wire abs_sel = ctrl_reg[`APT_CTRL_ABS_BIT]; // R1
    wire warn_sel = ctrl_reg[`APT_CTRL_WARN_BIT]; // R2
    wire avail = abs_sel & ~ctrl_reg[`APT_CTRL_NOSTROKE_BIT] // R10
        & ~ctrl_reg[`APT_CTRL_INC_BIT]; // R11

    // revolution count out of range is a counter fault
    wire signed [15:0] rev_s = I_REVOLUTION_COUNT;
    wire rev_oor = (rev_s == 16'sh8000); // R13
    wire data_lost = I_ENCODER_LINK_BROKEN | I_BACKUP_SWAPPED_UNPOWERED; // R12

    // any of these drops the done flag
    wire drop = ~I_SERVO_ON | ~I_FORCED_STOP_INPUT_A |
        ~I_FORCED_STOP_INPUT_B | I_ALARM_ACTIVE |
        ~I_SAFE_TORQUE_OFF_INPUT | I_MAIN_CIRCUIT_OFF_WARNING |
        ~I_STROKE_LIMIT_OK | I_SOFTWARE_LIMIT_HIT; // R5

    wire erase_evt = avail & (data_lost | (I_POWER_UP & stale_reg)); // R3
    wire cnt_evt = avail & warn_sel & rev_oor; // R2
    wire home_evt = I_HOME_RETURN_DONE & avail & ~drop;
    wire inc_evt = I_POSITION_CMD & ~O_HOME_RETURN_DONE_FLAG &
        ~home_evt; // R6

    // control and configuration registers
    always @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            ctrl_reg <= `APT_CTRL_RST;
        end else if (apb_wr && I_PADDR == `APT_OFS_CTRL) begin
            ctrl_reg <= I_PWDATA;
        end
    end

    // settings change only takes effect at next power-up; set wins clear
    always @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            stale_reg <= 1'b0;
        end else if (wr_cfg) begin
            stale_reg <= 1'b1; // R3
        end else if (I_POWER_UP) begin
            stale_reg <= 1'b0;
        end
    end

    // home reference capture and validity
    always @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            home_valid_reg <= 1'b0;
            turn_home_reg <= {TURN_W{1'b0}};
            rev_home_reg <= 16'sh0000;
        end else if (erase_evt | cnt_evt | ~avail) begin
            home_valid_reg <= 1'b0; // R7
        end else if (home_evt) begin
            home_valid_reg <= 1'b1; // R14
            turn_home_reg <= I_SINGLE_TURN_COUNT;
            rev_home_reg <= rev_s;
        end
    end

    // done flag: hardware drop beats home completion
    always @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            O_HOME_RETURN_DONE_FLAG <= 1'b0;
        end else if (drop | erase_evt | cnt_evt | ~avail) begin
            O_HOME_RETURN_DONE_FLAG <= 1'b0; // R5
        end else if (home_evt) begin
            O_HOME_RETURN_DONE_FLAG <= 1'b1; // R14
        end
    end

    // sticky alarms; a new event in the clear cycle wins
    always @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            O_ABS_DATA_ERASED_ALARM <= 1'b0;
            O_REVOLUTION_COUNTER_WARNING <= 1'b0;
            O_HOME_RETURN_INCOMPLETE_WARNING <= 1'b0;
        end else begin
            if (erase_evt) begin
                O_ABS_DATA_ERASED_ALARM <= 1'b1; // R7
            end else if (wr_clr && I_PWDATA[`APT_CLR_ERASED]) begin
                O_ABS_DATA_ERASED_ALARM <= 1'b0;
            end
            if (cnt_evt) begin
                O_REVOLUTION_COUNTER_WARNING <= 1'b1; // R7
            end else if (wr_clr && I_PWDATA[`APT_CLR_CNTWARN]) begin
                O_REVOLUTION_COUNTER_WARNING <= 1'b0;
            end
            if (inc_evt) begin
                O_HOME_RETURN_INCOMPLETE_WARNING <= 1'b1; // R6
            end else if (home_evt) begin
                O_HOME_RETURN_INCOMPLETE_WARNING <= 1'b0;
            end else if (wr_clr && I_PWDATA[`APT_CLR_INCWARN]) begin
                O_HOME_RETURN_INCOMPLETE_WARNING <= 1'b0;
            end
        end
    end

    // code shows the most serious pending condition
    always @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            O_ALARM_CODE <= 8'h00;
        end else if (O_ABS_DATA_ERASED_ALARM) begin
            O_ALARM_CODE <= `APT_CODE_ERASED;
        end else if (O_REVOLUTION_COUNTER_WARNING) begin
            O_ALARM_CODE <= `APT_CODE_CNTWARN;
        end else if (O_HOME_RETURN_INCOMPLETE_WARNING) begin
            O_ALARM_CODE <= `APT_CODE_INCWARN;
        end else begin
            O_ALARM_CODE <= 8'h00;
        end
    end

    // position relative to home; zero while the reference is invalid
    always @* begin
        pos_next = $signed({{32{rev_s[15]}}, rev_s} - {{32{rev_home_reg[15]}},
            rev_home_reg}) * $signed({16'h0000, COUNTS_PER_REV}); // R9
        pos_next = pos_next + $signed({{(48-TURN_W){1'b0}},
            I_SINGLE_TURN_COUNT}) - $signed({{(48-TURN_W){1'b0}},
            turn_home_reg}); // R8
    end

    always @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            O_ABS_POSITION <= 48'sh0;
        end else if (home_valid_reg) begin
            O_ABS_POSITION <= pos_next;
        end else begin
            O_ABS_POSITION <= 48'sh0;
        end
    end

    // read mux; write-only clear register reads zero
    always @* begin
        O_PRDATA = 32'h00000000;
        case (I_PADDR)
            `APT_OFS_CTRL: O_PRDATA = ctrl_reg;
            `APT_OFS_STAT: O_PRDATA = {25'h0, stale_reg, avail,
                O_HOME_RETURN_INCOMPLETE_WARNING,
                O_REVOLUTION_COUNTER_WARNING, O_ABS_DATA_ERASED_ALARM,
                home_valid_reg, O_HOME_RETURN_DONE_FLAG};
            `APT_OFS_REV: O_PRDATA = {{16{rev_s[15]}}, rev_s};
            `APT_OFS_TURN: O_PRDATA = {{(32-TURN_W){1'b0}},
                I_SINGLE_TURN_COUNT};
            `APT_OFS_REV_HOME: O_PRDATA = {{16{rev_home_reg[15]}},
                rev_home_reg};
            `APT_OFS_TURN_HOME: O_PRDATA = {{(32-TURN_W){1'b0}},
                turn_home_reg};
            `APT_OFS_POS: O_PRDATA = O_ABS_POSITION[31:0];
            default: O_PRDATA = 32'h00000000;
        endcase
    end

endmodule
`default_nettype wire

// ==== rtl/apt_regs.vh ====
// register offsets, fields and reset values of the position tracker
`ifndef APT_REGS_VH
`define APT_REGS_VH
`define APT_OFS_CTRL 12'h000
`define APT_OFS_CFG 12'h004
`define APT_OFS_STAT 12'h008
`define APT_OFS_REV 12'h00c
`define APT_OFS_TURN 12'h010
`define APT_OFS_REV_HOME 12'h014
`define APT_OFS_TURN_HOME 12'h018
`define APT_OFS_POS 12'h01c
`define APT_OFS_CLR 12'h020
// ctrl: bit0 tracking select, bit1 counter warning select,
// bit2 incremental command method, bit3 stroke-less axis
`define APT_CTRL_ABS_BIT 0
`define APT_CTRL_WARN_BIT 1
`define APT_CTRL_INC_BIT 2
`define APT_CTRL_NOSTROKE_BIT 3
`define APT_CTRL_RST 32'h00000000
// cfg: any write marks the home reference stale at next power-up
`define APT_CFG_RST 32'h00000000
// stat bits
`define APT_ST_DONE 0
`define APT_ST_VALID 1
`define APT_ST_ERASED 2
`define APT_ST_CNTWARN 3
`define APT_ST_INCWARN 4
`define APT_ST_AVAIL 5
`define APT_ST_STALE 6
// clear register bits (write one)
`define APT_CLR_ERASED 0
`define APT_CLR_CNTWARN 1
`define APT_CLR_INCWARN 2
// alarm and warning codes
`define APT_CODE_ERASED 8'h25
`define APT_CODE_CNTWARN 8'he3
`define APT_CODE_INCWARN 8'h90
`define APT_REV_LIMIT 32767
`endif

// ==== tb/apt_tracker_sva.sv ====
// port checker for the absolute position tracker
`timescale 1ns/1ps
`default_nettype none
module apt_tracker_sva #(parameter TURN_W = 18) (
    // clock, reset and encoder
    input wire I_CLK_SYS, I_SRST, I_POWER_UP,
    input wire [TURN_W-1:0] I_SINGLE_TURN_COUNT,
    input wire [15:0] I_REVOLUTION_COUNT,
    input wire I_ENCODER_LINK_BROKEN, I_BACKUP_SWAPPED_UNPOWERED,
    // servo status and controller
    input wire I_SERVO_ON, I_FORCED_STOP_INPUT_A, I_FORCED_STOP_INPUT_B,
    input wire I_ALARM_ACTIVE, I_SAFE_TORQUE_OFF_INPUT, I_STROKE_LIMIT_OK,
    input wire I_MAIN_CIRCUIT_OFF_WARNING, I_SOFTWARE_LIMIT_HIT,
    input wire I_HOME_RETURN_DONE, I_POSITION_CMD,
    // watched outputs
    input wire O_HOME_RETURN_DONE_FLAG, O_ABS_DATA_ERASED_ALARM,
    input wire O_REVOLUTION_COUNTER_WARNING, O_HOME_RETURN_INCOMPLETE_WARNING,
    input wire [7:0] O_ALARM_CODE,
    input wire signed [47:0] O_ABS_POSITION
);
    // short aliases and the merged drop cause
    wire flg = O_HOME_RETURN_DONE_FLAG;
    wire ers = O_ABS_DATA_ERASED_ALARM;
    wire cw = O_REVOLUTION_COUNTER_WARNING;
    wire iw = O_HOME_RETURN_INCOMPLETE_WARNING;
    wire drop = !I_SERVO_ON | !I_FORCED_STOP_INPUT_A | !I_FORCED_STOP_INPUT_B
        | I_ALARM_ACTIVE | !I_SAFE_TORQUE_OFF_INPUT | !I_STROKE_LIMIT_OK
        | I_MAIN_CIRCUIT_OFF_WARNING | I_SOFTWARE_LIMIT_HIT;
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_SRST);
    // homed with the encoder still, so the offset must be zero
    sequence s_homed;
        $rose(flg) && $stable(I_SINGLE_TURN_COUNT)
            && $stable(I_REVOLUTION_COUNT);
    endsequence
    sequence s_unhomed;
        I_POSITION_CMD && !flg && !I_HOME_RETURN_DONE;
    endsequence
    a_drop_clears: assert property (drop |=> !flg)
        else $error("done flag survived a drop cause");
    a_done_cause: assert property ($rose(flg) |-> $past(I_HOME_RETURN_DONE))
        else $error("done flag rose without a home event");
    a_home_zero: assert property (s_homed |=> O_ABS_POSITION == 48'sd0)
        else $error("position not zero at home");
    a_incomp_set: assert property (s_unhomed |=> iw)
        else $error("incomplete warning missing");
    a_incomp_code: assert property ($rose(iw) && !ers && !cw |=>
        O_ALARM_CODE == 8'h90) else $error("wrong incomplete code");
    a_erase_code: assert property ($rose(ers) && !cw && !iw |=>
        O_ALARM_CODE == 8'h25) else $error("wrong erased code");
    a_erase_drop: assert property ($rose(ers) |-> ##[0:1] !flg)
        else $error("done flag kept after erase");
    a_cnt_range: assert property ($rose(cw) |->
        $past(I_REVOLUTION_COUNT) == 16'h8000)
        else $error("counter warn in range");
    a_erase_cause: assert property ($rose(ers) |-> $past(I_POWER_UP
        | I_ENCODER_LINK_BROKEN | I_BACKUP_SWAPPED_UNPOWERED))
        else $error("erase without a cause");
endmodule
bind apt_tracker apt_tracker_sva #(.TURN_W(TURN_W)) apt_tracker_sva_i (.*);
`default_nettype wire

// ==== tb/apt_ctrl_model.sv ====
// motion controller model issuing home and positioning pulses
`timescale 1ns/1ps
`default_nettype none
module apt_ctrl_model (
    // clock and bench requests
    input wire logic clk,
    input wire logic req_home,
    input wire logic req_pos,
    input wire logic force_pos,
    input wire logic done_flag,
    // pulses to the tracker
    output var logic home_done = 1'b0,
    output var logic pos_cmd = 1'b0
);
    // positioning is dropped without the done flag unless the bench forces it
    always @(posedge clk) begin
        home_done <= req_home;
        pos_cmd <= req_pos && (done_flag || force_pos);
    end
endmodule
`default_nettype wire

// ==== tb/apt_tracker_tb.sv ====
// self-checking bench for the absolute position tracker
`timescale 1ns/1ps
`default_nettype none
`include "apt_regs.vh"
module apt_tracker_tb;
    localparam int CPR = 1024;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, ready, slverr, done;
    logic lost = 0, swap = 0, pup = 0, rq_h = 0, rq_p = 0, frc = 0, hdn, pcm;
    logic [11:0] pa = '0;
    logic [31:0] pwd = '0, prd;
    logic [9:0] turn = '0;
    logic [15:0] rev = '0;
    logic [7:0] code;
    logic [7:0] ok = 8'hff; // drop causes, one means healthy
    logic [3:0] cv [3] = '{4'h0, 4'h5, 4'h9};
    logic [31:0] eq[$], mq[$];
    int n_fail = 0, checked = 0, seed = 32'hc2d0;
    apt_tracker #(.TURN_W(10), .COUNTS_PER_REV(CPR)) apt_tracker_i (
        .I_CLK_SYS(clk), .I_SRST(rst), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pwd), .O_PREADY(ready),
        .O_PSLVERR(slverr), .O_PRDATA(prd), .I_SINGLE_TURN_COUNT(turn),
        .I_REVOLUTION_COUNT(rev), .I_ENCODER_LINK_BROKEN(lost),
        .I_BACKUP_SWAPPED_UNPOWERED(swap), .I_POWER_UP(pup),
        .I_SERVO_ON(ok[0]), .I_FORCED_STOP_INPUT_A(ok[1]),
        .I_FORCED_STOP_INPUT_B(ok[2]), .I_ALARM_ACTIVE(!ok[3]),
        .I_SAFE_TORQUE_OFF_INPUT(ok[4]), .I_MAIN_CIRCUIT_OFF_WARNING(!ok[5]),
        .I_STROKE_LIMIT_OK(ok[6]), .I_SOFTWARE_LIMIT_HIT(!ok[7]),
        .I_HOME_RETURN_DONE(hdn), .I_POSITION_CMD(pcm),
        .O_HOME_RETURN_DONE_FLAG(done), .O_ABS_DATA_ERASED_ALARM(),
        .O_REVOLUTION_COUNTER_WARNING(), .O_HOME_RETURN_INCOMPLETE_WARNING(),
        .O_ALARM_CODE(code), .O_ABS_POSITION());
    apt_ctrl_model apt_ctrl_model_i (.clk(clk), .req_home(rq_h),
        .req_pos(rq_p), .force_pos(frc), .done_flag(done),
        .home_done(hdn), .pos_cmd(pcm));
    initial forever #12.5 clk = ~clk;
    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one apb transfer; reads leave their expectation for the monitor
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [31:0] m);
        int k;
        if (!w) begin
            eq.push_back(d);
            mq.push_back(m);
        end
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        k = 0;
        do @(posedge clk); while (!ready && ++k < 20);
        if (!ready) begin
            n_fail++;
            close_out();
        end
        psel <= 0;
        pen <= 0;
    endtask
    // home return via the controller model, then let it settle
    task automatic home;
        rq_h <= 1;
        @(posedge clk);
        rq_h <= 0;
        repeat (3) @(posedge clk);
    endtask
    task automatic posn(input logic f);
        frc <= f;
        rq_p <= 1;
        @(posedge clk);
        rq_p <= 0;
    endtask
    // read monitor: oldest expectation against completed access
    always @(posedge clk) begin
        if (psel && pen && ready) begin
            chk(slverr, pa > `APT_OFS_CLR);
            if (!pwr) begin
                chk(prd & mq[0], eq[0] & mq[0]);
                void'(eq.pop_front());
                void'(mq.pop_front());
            end
        end
    end
    // scenarios; each leaves the sticky flags clear for the next
    initial begin
        logic [31:0] r, e;
        repeat (2) @(posedge clk);
        rst <= 0;
        apb(0, `APT_OFS_CTRL, `APT_CTRL_RST, '1);
        apb(0, `APT_OFS_STAT, 0, 32'h1d);
        apb(0, 12'h024, 0, '1);
        apb(1, `APT_OFS_CTRL, 1, 0);
        r = $random(seed);
        turn <= r[9:0];
        home();
        apb(0, `APT_OFS_STAT, 1, 32'h1d);
        e = CPR - r[9:0];
        r = $random(seed);
        turn <= r[9:0];
        rev <= 1;
        apb(0, `APT_OFS_POS, e + r[9:0], '1);
        for (int i = 0; i < 8; i++) begin
            home();
            ok[i] <= 0;
            @(posedge clk);
            ok[i] <= 1;
            apb(0, `APT_OFS_STAT, 0, 1);
        end
        posn(0);
        apb(0, `APT_OFS_STAT, 0, 32'h10);
        posn(1);
        apb(0, `APT_OFS_STAT, 32'h10, 32'h10);
        @(negedge clk); // code lags the flag; look once it has settled
        chk(code, 8'h90);
        apb(1, `APT_OFS_CLR, 4, 0);
        apb(0, `APT_OFS_STAT, 0, 32'h10);
        rev <= 16'h8000;
        apb(0, `APT_OFS_STAT, 0, 8);
        rev <= 0;
        apb(1, `APT_OFS_CTRL, 3, 0);
        home();
        rev <= 16'h8000;
        apb(0, `APT_OFS_STAT, 8, 9);
        @(negedge clk);
        chk(code, 8'he3);
        rev <= 0;
        apb(1, `APT_OFS_CLR, 2, 0);
        home();
        apb(0, `APT_OFS_STAT, 1, 9);
        for (int j = 0; j < 2; j++) begin
            home();
            lost <= (j == 0);
            swap <= (j == 1);
            @(posedge clk);
            lost <= 0;
            swap <= 0;
            apb(0, `APT_OFS_STAT, 4, 5);
            @(negedge clk);
            chk(code, 8'h25);
            apb(1, `APT_OFS_CLR, 1, 0);
        end
        home();
        apb(1, `APT_OFS_CFG, 32'h5, 0);
        apb(0, `APT_OFS_STAT, 32'h42, 32'h42);
        pup <= 1;
        @(posedge clk);
        pup <= 0;
        apb(0, `APT_OFS_STAT, 0, 2);
        apb(1, `APT_OFS_CLR, 1, 0);
        for (int k = 0; k < 3; k++) begin
            apb(1, `APT_OFS_CTRL, {28'h0, cv[k]}, 0);
            home();
            apb(0, `APT_OFS_STAT, 0, 32'h21);
        end
        close_out();
    end
endmodule
`default_nettype wire
